// ===== core/drs_debug_run_status.sv
// Summary of operation
// - Run start clears comparator one hit, match sets
// - Run start clears comparator two hit, match sets
// - Status bit 5 mirrors armed while enabled
// - Writing arm 1 while enabled sets flag
// - Full FIFO in begin trace or trigger in end trace ends run automatically
// - Writing arm or enable 0 stops run
// - Count cleared at start, holds words at end
// - Reading trace words never decrements the count
// - Count is plain binary, zero to eight
// - Status register ignores all writes
// - Select 0 stores until trigger, 1 after
// - Event-only modes always behave as begin trace
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "drs_defines.svh"

module drs_debug_run_status
    import drs_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Debug events, same clock
    input  wire logic        comp_one_match,
    input  wire logic        comp_two_match,
    input  wire logic        trigger_event,
    input  wire logic        fifo_word_stored,
    input  wire logic        fifo_full,
    // Run status to the trace logic
    output logic             capture_active,
    output logic             trace_store_enable
);

    drs_run_state_t run_state_reg;
    drs_run_state_t run_state_next;

    logic        dp_write_reg;
    logic        dp_ctrl_sel_reg;
    logic        dp_stat_sel_reg;
    logic [31:0] hrdata_reg;
    logic        debug_unit_enable_reg;
    logic        begin_select_reg;
    logic [3:0]  trigger_mode_select_reg;

    logic        addr_valid;
    logic        addr_is_ctrl;
    logic        addr_is_stat;
    logic        ctrl_wr;
    logic        wr_enable;
    logic        wr_arm;
    logic        wr_begin;
    logic [3:0]  wr_mode;
    logic        armed;
    logic        start_run;
    logic        manual_stop;
    logic        auto_end;
    logic        begin_eff;
    logic        begin_at_start;
    logic        comparator_one_hit_flag;
    logic        comparator_two_hit_flag;
    logic        capture_active_flag;
    logic [3:0]  trace_valid_count;
    logic [7:0]  ctrl_image;
    logic [7:0]  status_image;

    // Event-only modes have no end trace
    function automatic logic is_event_only(input logic [3:0] mode);
        is_event_only = (mode == `DRS_MODE_EVENT_B) || (mode == `DRS_MODE_A_EVENT_B);
    endfunction

    // Address phase decode; only whole-word writes are honoured, reads of any size are served
    assign addr_valid   = hsel && htrans[1] && hready;
    assign addr_is_ctrl = (haddr[`DRS_ADDR_BITS-1:0] == `DRS_CTRL_OFFSET);
    assign addr_is_stat = (haddr[`DRS_ADDR_BITS-1:0] == `DRS_STATUS_OFFSET);

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = `DRS_HRESP_OKAY;
    assign hrdata    = hrdata_reg;

    // Data phase bookkeeping
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dp_write_reg    <= 1'b0;
            dp_ctrl_sel_reg <= 1'b0;
            dp_stat_sel_reg <= 1'b0;
        end else if (hready) begin
            dp_write_reg    <= addr_valid && hwrite && (hsize == `DRS_HSIZE_WORD);
            dp_ctrl_sel_reg <= addr_valid && addr_is_ctrl;
            dp_stat_sel_reg <= addr_valid && addr_is_stat;
        end
    end

    // Write data fields of a control write
    assign ctrl_wr   = dp_write_reg && dp_ctrl_sel_reg;
    assign wr_enable = hwdata[`DRS_CTRL_EN_BIT];
    assign wr_arm    = hwdata[`DRS_CTRL_ARM_BIT];
    assign wr_begin  = hwdata[`DRS_CTRL_BEGIN_BIT];
    assign wr_mode   = hwdata[`DRS_CTRL_MODE_MSB:`DRS_CTRL_MODE_LSB];

    // Enable bit, writable at any time
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            debug_unit_enable_reg <= 1'b0;
        end else if (ctrl_wr) begin
            debug_unit_enable_reg <= wr_enable;
        end
    end

    // Trace setup is frozen while armed so a run cannot change shape midway
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            begin_select_reg        <= 1'b0;
            trigger_mode_select_reg <= `DRS_MODE_RESET;
        end else if (ctrl_wr && !armed) begin
            begin_select_reg        <= wr_begin;
            trigger_mode_select_reg <= wr_mode;
        end
    end

    // Run start and stop conditions
    assign armed          = (run_state_reg != DRS_RUN_IDLE);
    assign start_run      = ctrl_wr && wr_enable && wr_arm && !armed;
    assign manual_stop    = ctrl_wr && armed && (!wr_enable || !wr_arm);
    assign begin_eff      = begin_select_reg || is_event_only(trigger_mode_select_reg);
    assign begin_at_start = wr_begin || is_event_only(wr_mode);

    // Full FIFO ends a begin trace, a trigger ends an end trace
    assign auto_end = (run_state_reg == DRS_RUN_STORE) &&
                      ((begin_eff && fifo_full) || (!begin_eff && trigger_event));

    // Run sequencer; a stop write or completion wins over everything else
    always_comb begin
        run_state_next = run_state_reg;
        case (run_state_reg)
            DRS_RUN_IDLE: begin
                if (start_run) begin
                    run_state_next = begin_at_start ? DRS_RUN_WAIT_TRIG : DRS_RUN_STORE;
                end
            end
            DRS_RUN_WAIT_TRIG: begin
                if (manual_stop) begin
                    run_state_next = DRS_RUN_IDLE;
                end else if (trigger_event) begin
                    run_state_next = DRS_RUN_STORE;
                end
            end
            DRS_RUN_STORE: begin
                if (manual_stop || auto_end) begin
                    run_state_next = DRS_RUN_IDLE;
                end
            end
            default: begin
                run_state_next = DRS_RUN_IDLE;
            end
        endcase
    end

    // Run state register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_state_reg <= DRS_RUN_IDLE;
        end else begin
            run_state_reg <= run_state_next;
        end
    end

    // Comparator one hit, counted only since arming
    drs_hit_flag u_hit_one (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .clear   (start_run),
        .set     (comp_one_match && (armed || start_run)),
        .flag    (comparator_one_hit_flag)
    );

    // Comparator two hit, counted only since arming
    drs_hit_flag u_hit_two (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .clear   (start_run),
        .set     (comp_two_match && (armed || start_run)),
        .flag    (comparator_two_hit_flag)
    );

    // Valid words; FIFO reads are not seen here, so the host must count
    drs_valid_counter u_count (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .clear   (start_run),
        .inc     (fifo_word_stored && (run_state_reg == DRS_RUN_STORE)),
        .count   (trace_valid_count)
    );

    // Armed image is only meaningful while the unit is enabled
    assign capture_active_flag = debug_unit_enable_reg && armed;
    assign capture_active      = armed;
    assign trace_store_enable  = (run_state_reg == DRS_RUN_STORE);

    // Register images; bit 4 of status is unused
    assign ctrl_image   = {debug_unit_enable_reg, armed, begin_select_reg, 1'b0,
                           trigger_mode_select_reg};
    assign status_image = {comparator_one_hit_flag, comparator_two_hit_flag,
                           capture_active_flag, 1'b0, trace_valid_count};

    // Read data sampled in the address phase; status writes land nowhere
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (addr_valid && !hwrite) begin
            if (addr_is_ctrl) begin
                hrdata_reg <= {24'h00_0000, ctrl_image};
            end else if (addr_is_stat) begin
                hrdata_reg <= {24'h00_0000, status_image};
            end else begin
                hrdata_reg <= 32'h0000_0000;
            end
        end
    end

    // Start clears comparator one hit unless it matches that cycle
    a_start_clears_one: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        start_run && !comp_one_match |=> !comparator_one_hit_flag
    ) else $error("comparator one hit not cleared at run start");

    // Match while armed sets comparator two hit and it stays set
    a_two_hit_sticks: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        armed && comp_two_match && !start_run |=> comparator_two_hit_flag [*2]
    ) else $error("comparator two hit not set or not held");

    // Armed image follows the state while enabled
    a_armed_image: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        debug_unit_enable_reg |-> (status_image[`DRS_STAT_ARMED_BIT] ==
                                   (run_state_reg != DRS_RUN_IDLE))
    ) else $error("armed image differs from armed state");

    // Arm write shows as armed in the status read path next cycle
    a_arm_sets_flag: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        start_run |=> capture_active_flag && capture_active
    ) else $error("arm write did not set armed flag");

    // Completion clears the armed flag one cycle later
    a_auto_end: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        auto_end |=> !capture_active_flag && (run_state_reg == DRS_RUN_IDLE)
    ) else $error("run did not end on completion");

    // Stop write ends the run at once
    a_manual_stop: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        manual_stop |=> !capture_active && !trace_store_enable
    ) else $error("stop write did not end run");

    // Count is zero right after a start
    a_count_cleared: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        start_run |=> (trace_valid_count == `DRS_COUNT_RESET)
    ) else $error("valid count not cleared at start");

    // Count frozen between runs
    a_count_holds: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !armed && !start_run |=> $stable(trace_valid_count)
    ) else $error("valid count changed outside a run");

    // Count steps by one per stored word while below the trace depth
    a_count_range: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        fifo_word_stored && (run_state_reg == DRS_RUN_STORE) &&
        (trace_valid_count < `DRS_COUNT_MAX) |=>
        (trace_valid_count == $past(trace_valid_count) + 4'h1)
    ) else $error("valid count did not step by one");

    // Status write between runs changes no status bit
    a_status_ro: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        dp_write_reg && dp_stat_sel_reg && !armed |=> $stable(status_image)
    ) else $error("status write altered status");

    // Begin trace waits for the trigger before storing
    a_begin_waits: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        start_run && begin_at_start |=> !trace_store_enable ##0 armed
    ) else $error("begin trace stored before trigger");

    // Trigger in event-only mode does not end the run
    a_event_only_begin: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (run_state_reg == DRS_RUN_STORE) && is_event_only(trigger_mode_select_reg) &&
        trigger_event && !fifo_full && !ctrl_wr |=> trace_store_enable
    ) else $error("event-only run ended on trigger");

    // Match while armed sets comparator one hit
    a_one_hit_sets: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        armed && comp_one_match && !start_run |=> comparator_one_hit_flag
    ) else $error("comparator one hit not set by match");

    // Start clears comparator two hit unless it matches that cycle
    a_start_clears_two: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        start_run && !comp_two_match |=> !comparator_two_hit_flag
    ) else $error("comparator two hit not cleared at run start");

    // End trace stores from the first cycle of the run
    a_end_stores: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        start_run && !begin_at_start |=> trace_store_enable
    ) else $error("end trace did not store at once");

    // Trigger in a begin trace starts storage
    a_trigger_starts: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        (run_state_reg == DRS_RUN_WAIT_TRIG) && trigger_event && !manual_stop |=>
        trace_store_enable && armed
    ) else $error("trigger did not start storage");

    // Count never passes the trace depth
    a_count_max: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        trace_valid_count <= `DRS_COUNT_MAX
    ) else $error("valid count above trace depth");

    // Unused status bit stays zero
    a_rsvd_zero: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        status_image[`DRS_STAT_RSVD_BIT] == 1'b0
    ) else $error("unused status bit not zero");

endmodule

// ===== core/drs_defines.svh
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH

// Register byte offsets, compared on the low address bits
`define DRS_ADDR_BITS       12
`define DRS_CTRL_OFFSET     12'h000
`define DRS_STATUS_OFFSET   12'h004

// Control register fields
`define DRS_CTRL_EN_BIT     7
`define DRS_CTRL_ARM_BIT    6
`define DRS_CTRL_BEGIN_BIT  5
`define DRS_CTRL_MODE_MSB   3
`define DRS_CTRL_MODE_LSB   0

// Status register fields
`define DRS_STAT_ONE_BIT    7
`define DRS_STAT_TWO_BIT    6
`define DRS_STAT_ARMED_BIT  5
`define DRS_STAT_RSVD_BIT   4
`define DRS_STAT_COUNT_MSB  3
`define DRS_STAT_COUNT_LSB  0

// Reset values
`define DRS_CTRL_RESET      8'h00
`define DRS_STATUS_RESET    8'h00
`define DRS_MODE_RESET      4'h0
`define DRS_COUNT_RESET     4'h0

// Trace depth and event-only trigger modes
`define DRS_COUNT_MAX       4'h8
`define DRS_MODE_EVENT_B    4'h3
`define DRS_MODE_A_EVENT_B  4'h4

// AHB encodings
`define DRS_HSIZE_WORD      3'h2
`define DRS_HRESP_OKAY      1'h0

`endif

// ===== core/drs_pkg.sv
package drs_pkg;

    // Debug run sequencing
    typedef enum logic [1:0] {
        DRS_RUN_IDLE      = 2'b00,
        DRS_RUN_WAIT_TRIG = 2'b01,
        DRS_RUN_STORE     = 2'b10
    } drs_run_state_t;

endpackage

// ===== core/drs_hit_flag.sv
`timescale 1ns/1ps
`include "drs_defines.svh"

module drs_hit_flag (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Control
    input  wire logic clear,
    input  wire logic set,
    // Flag
    output logic      flag
);

    logic flag_reg;

    // Sticky flag; a set in the clearing cycle is kept
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_reg <= 1'b0;
        end else if (set) begin
            flag_reg <= 1'b1;
        end else if (clear) begin
            flag_reg <= 1'b0;
        end
    end

    assign flag = flag_reg;

endmodule

// ===== core/drs_valid_counter.sv
`timescale 1ns/1ps
`include "drs_defines.svh"

module drs_valid_counter (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // Control
    input  wire logic       clear,
    input  wire logic       inc,
    // Count
    output logic [3:0]      count
);

    logic [3:0] count_reg;
    logic [3:0] count_next;

    // Saturates at trace depth; nothing here ever decrements
    always_comb begin
        count_next = count_reg;
        if (clear) begin
            count_next = `DRS_COUNT_RESET;
        end else if (inc && (count_reg < `DRS_COUNT_MAX)) begin
            count_next = count_reg + 4'h1;
        end
    end

    // Count register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= `DRS_COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;

endmodule

// ===== dv/drs_host_model.sv
`timescale 1ns/1ps
`include "drs_defines.svh"

module drs_host_model (
    // Clock
    input  wire logic        sys_clk,
    // AHB-Lite master side
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // Host bookkeeping
    output logic             hang,
    output logic [3:0]       words_left
);
    // Bus idle until the bench asks for a transfer
    initial begin
        hsel       = 1'b0;
        haddr      = 32'h0000_0000;
        htrans     = 2'b00;
        hwrite     = 1'b0;
        hsize      = `DRS_HSIZE_WORD;
        hwdata     = 32'h0000_0000;
        hang       = 1'b0;
        words_left = 4'h0;
    end

    // One single word transfer; call just after a rising edge
    task automatic xfer(input logic wr, input logic [31:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= `DRS_HSIZE_WORD;
        hwdata <= ~hwdata; // Stale data never looks valid
        @(posedge sys_clk);
        while (hready !== 1'b1 && n < 16) begin
            @(posedge sys_clk);
            n++;
        end
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge sys_clk);
        while (hready !== 1'b1 && n < 32) begin
            @(posedge sys_clk);
            n++;
        end
        rd = hrdata;
        if (n >= 16) begin
            hang <= 1'b1;
        end
        // Count never drops on read-out, so the host keeps its own copy
        if (!wr && a[11:0] == `DRS_STATUS_OFFSET) begin
            words_left <= rd[3:0];
        end
    endtask
endmodule

// ===== dv/drs_debug_run_status_tb_top.sv
`timescale 1ns/1ps
`include "drs_defines.svh"

module drs_debug_run_status_tb_top;
    localparam logic [31:0] CTRL  = {20'h0_0000, `DRS_CTRL_OFFSET};
    localparam logic [31:0] STAT  = {20'h0_0000, `DRS_STATUS_OFFSET};
    localparam logic [31:0] NOMAP = 32'h0000_0100;
    // Event bits: one, two, trigger, word, full
    localparam logic [4:0]  ONE = 5'h10, TWO = 5'h08, TRIG = 5'h04;
    localparam logic [4:0]  WRD = 5'h02, FUL = 5'h01;

    logic        sys_clk, reset_n;
    logic        hsel, hwrite, hready, hresp, capture_active, trace_store_enable;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        comp_one_match, comp_two_match, trigger_event;
    logic        fifo_word_stored, fifo_full;
    logic        hang;
    logic [3:0]  words_left;
    int          bad_count, comparisons;

    // Clock and reset
    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        {comp_one_match, comp_two_match, trigger_event, fifo_word_stored, fifo_full} = 5'h00;
    end
    always #4 sys_clk = ~sys_clk;

    drs_debug_run_status drs_debug_run_status_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .comp_one_match(comp_one_match), .comp_two_match(comp_two_match),
        .trigger_event(trigger_event), .fifo_word_stored(fifo_word_stored),
        .fifo_full(fifo_full), .capture_active(capture_active),
        .trace_store_enable(trace_store_enable));

    drs_host_model drs_host_model_i (
        .sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hang(hang), .words_left(words_left));

    task automatic give_verdict();
        if (hang) begin
            bad_count++;
        end
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Register and bookkeeping values
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Run outputs, sampled mid-cycle so the edge updates have landed
    task automatic chk_run(input logic ca, input logic se);
        @(negedge sys_clk);
        comparisons++;
        if ({capture_active, trace_store_enable} !== {ca, se}) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time,
                     {capture_active, trace_store_enable}, {ca, se});
        end
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        drs_host_model_i.xfer(1'b1, a, d, r);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] r;
        drs_host_model_i.xfer(1'b0, a, 32'h0000_0000, r);
        chk(r, exp);
    endtask

    // Hold the chosen events high for cnt cycles
    task automatic ev(input logic [4:0] v, input int cnt);
        {comp_one_match, comp_two_match, trigger_event, fifo_word_stored, fifo_full} <= v;
        repeat (cnt) @(posedge sys_clk);
        {comp_one_match, comp_two_match, trigger_event, fifo_word_stored, fifo_full} <= 5'h00;
        // Idle edge so a following call never reassigns in this time step
        @(posedge sys_clk);
    endtask

    task automatic t_reset();
        chk_run(1'b0, 1'b0);
        rd_chk(STAT, 32'h0000_0000);
        rd_chk(CTRL, 32'h0000_0000);
        wr(STAT, 32'h0000_00FF);
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
        rd_chk(STAT, 32'h0000_0000);
        rd_chk(NOMAP, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_end_trace();
        wr(CTRL, 32'h0000_00C0);
        chk_run(1'b1, 1'b1);
        rd_chk(STAT, 32'h0000_0020);
        ev(ONE, 1);
        ev(WRD, 3);
        rd_chk(STAT, 32'h0000_00A3);
        wr(STAT, 32'h0000_0000);
        rd_chk(STAT, 32'h0000_00A3);
        ev(TRIG, 1);
        chk_run(1'b0, 1'b0);
        rd_chk(STAT, 32'h0000_0083);
        ev(WRD, 2);
        rd_chk(STAT, 32'h0000_0083);
        chk({28'h000_0000, words_left}, 32'h0000_0003);
        $display("test end trace done");
    endtask

    task automatic t_saturate();
        wr(CTRL, 32'h0000_00C0);
        rd_chk(STAT, 32'h0000_0020);
        ev(TWO, 1);
        ev(WRD, 10);
        rd_chk(STAT, 32'h0000_0068);
        wr(CTRL, 32'h0000_0080);
        chk_run(1'b0, 1'b0);
        ev(ONE, 1);
        rd_chk(STAT, 32'h0000_0048);
        rd_chk(CTRL, 32'h0000_0080);
        $display("test saturate done");
    endtask

    // Begin trace, explicit or forced by an event-only mode
    task automatic t_begin(input logic [31:0] c);
        wr(CTRL, c);
        chk_run(1'b1, 1'b0);
        ev(WRD, 2);
        ev(TRIG, 1);
        chk_run(1'b1, 1'b1);
        ev(WRD, 2);
        ev(TRIG, 1);
        chk_run(1'b1, 1'b1);
        ev(FUL, 1);
        chk_run(1'b0, 1'b0);
        rd_chk(STAT, 32'h0000_0002);
        $display("test begin %h done", c[7:0]);
    endtask

    // Reset in the middle of a run wipes every status bit
    task automatic t_reset_mid();
        wr(CTRL, 32'h0000_00C0);
        ev(ONE | WRD, 2);
        rd_chk(STAT, 32'h0000_00A2);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        chk_run(1'b0, 1'b0);
        rd_chk(STAT, 32'h0000_0000);
        rd_chk(CTRL, 32'h0000_0000);
        $display("test reset mid run done");
    endtask

    task automatic t_stop_en();
        wr(CTRL, 32'h0000_0040);
        chk_run(1'b0, 1'b0);
        wr(CTRL, 32'h0000_00C0);
        wr(CTRL, 32'h0000_0040);
        chk_run(1'b0, 1'b0);
        rd_chk(STAT, 32'h0000_0000);
        $display("test stop enable done");
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_end_trace();
        t_saturate();
        t_begin(32'h0000_00E0);
        t_begin(32'h0000_00C3);
        t_begin(32'h0000_00C4);
        t_reset_mid();
        t_stop_en();
        give_verdict();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        give_verdict();
    end
endmodule
